// [cpc_pkg.sv]
package cpc_pkg;
    // Register offsets on the plain port
    localparam logic [4:0] REG_CMD = 5'h00;
    localparam logic [4:0] REG_INSTR = 5'h04;
    localparam logic [4:0] REG_TARGET = 5'h08;
    localparam logic [4:0] REG_WP = 5'h0c;
    localparam logic [4:0] REG_PC = 5'h10;
    localparam logic [4:0] REG_ST = 5'h14;
    localparam logic [4:0] REG_STATUS = 5'h18;
    localparam logic [4:0] REG_FETCHED = 5'h1c;
    // Command codes in bits 2:0 of the command register
    localparam logic [2:0] CMD_DONE = 3'h0;
    localparam logic [2:0] CMD_SET = 3'h1;
    localparam logic [2:0] CMD_TEST = 3'h2;
    localparam logic [2:0] CMD_LINK = 3'h3;
    localparam logic [2:0] CMD_RET = 3'h4;
    localparam logic [2:0] CMD_XOP = 3'h5;
    // Status and instruction bit positions (bit n counted from the MSB sits at 15-n)
    localparam int ST_EQ_POS = 13;
    localparam int ST_XOP_POS = 9;
    localparam int INSTR_VAL_POS = 8;
    // Vector layout, byte addresses
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_XOP_BASE = 16'h0040;
    localparam logic [15:0] VEC_NMI = 16'hfffc;
    // Workspace byte offsets of registers 12 to 15
    localparam logic [15:0] WS_R12 = 16'h0018;
    localparam logic [15:0] WS_R13 = 16'h001a;
    localparam logic [15:0] WS_R14 = 16'h001c;
    localparam logic [15:0] WS_R15 = 16'h001e;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] ST_RESET = 16'h0000;
    localparam logic [2:0] TRAP_LAST = 3'h5;
    localparam logic [2:0] RET_LAST = 3'h2;
    localparam int MAX_MEM_RUN = 3;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SETUP = 3'b001,
        S_MEM1 = 3'b010,
        S_MEM2 = 3'b011,
        S_HOLD = 3'b100,
        S_IO_ADDR = 3'b101,
        S_IO_XFER = 3'b110
    } cpc_state_type;

    typedef enum logic [1:0] {
        SEQ_TRAP = 2'b00,
        SEQ_RET = 2'b01,
        SEQ_BIT = 2'b10
    } cpc_seq_type;

    typedef enum logic [2:0] {
        K_INT = 3'b000,
        K_RESET = 3'b001,
        K_NMI = 3'b010,
        K_LINK = 3'b011,
        K_XOP = 3'b100
    } cpc_kind_type;
endpackage : cpc_pkg

// [cpc_ctl.sv]
// Notes on behaviour
// - Hold is taken at a non-memory slot; at most three memory cycles first.
// - Hold ack within setup plus (6+3W) cycles plus one.
// - In hold ack high, bus and controls float; resume on release.
// - Hold inside a bit transfer costs one re-drive address cycle.
// - Output bit: address and value, strobe in second cycle.
// - Input bit: address, sample next cycle, no strobe.
// - Memory is 16-bit words on even byte addresses, 64 KiB.
// - Vectors: 32 interrupt words, 32 extended words, trap at top.
// - Register n is a memory word at workspace pointer plus 2n.
// - Context switch uses three stores and three fetches.
// - Branch, return, extended op, interrupts, reset, trap switch context.
// - Sixteen levels, zero is reset, 1 to 15 external.
// - Level code at or below mask is taken after the instruction.
// - Load new pointer and counter, save old in R13 to R15.
// - Mask becomes level minus one; zero for level zero.
// - No recognition until the first service instruction has run.
// - Return restores pointer, counter and status from R13 to R15.
// - 4096 bit addresses on A3 to A14.
// - Set operations drive instruction bit 7 and one strobe.
// - Test copies the input bit into the equal flag.
// - Bit address is base plus signed displacement, -128 to +127.
// - Base is bits 3 to 14 of the base register.
// - Level code sampled only while request is low; zero ignored.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module cpc_ctl
    import cpc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Memory bus
    output logic [14:0] addr_out,
    output logic addr_oe,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic read_direction,
    output logic mem_cycle_n,
    output logic write_strobe_n,
    output logic bus_ctl_oe,
    input wire logic mem_ready,
    // Bus hold
    input wire logic bus_yield_request_n,
    output logic bus_yield_ack,
    // Bit I/O
    output logic serial_out_bit,
    input wire logic serial_in_bit,
    output logic io_strobe,
    // Interrupt inputs
    input wire logic int_request_n,
    input wire logic [3:0] int_level_code,
    input wire logic nmi_trap_request_n
);
    cpc_state_type state_reg, state_next, resume_reg;
    cpc_seq_type seq_reg;
    cpc_kind_type kind_reg;
    logic [2:0] step_reg;
    logic [15:0] wp_reg, pc_reg, st_reg, instr_reg, target_reg;
    logic [15:0] vec_reg, nwp_reg, npc_reg, base_reg, fetched_reg;
    logic [3:0] level_reg, int_code_reg;
    logic hold_seen_reg, int_seen_reg, nmi_prev_reg, nmi_pend_reg;
    logic reset_pend_reg, inhibit_reg, io_out_reg, cyc_write_reg;

    // Word address of a byte address
    function automatic logic [14:0] word_of(input logic [15:0] a);
        word_of = a[15:1];
    endfunction : word_of

    // Access decode for the current step
    function automatic logic [15:0] seq_addr(input cpc_seq_type s, input logic [2:0] n);
        seq_addr = wp_reg + WS_R12;
        if (s == SEQ_TRAP) begin
            case (n)
                3'h0: seq_addr = vec_reg;
                3'h1: seq_addr = vec_reg + WORD_STEP;
                3'h2: seq_addr = nwp_reg + WS_R13;
                3'h3: seq_addr = nwp_reg + WS_R14;
                3'h4: seq_addr = nwp_reg + WS_R15;
                default: seq_addr = npc_reg;
            endcase
        end else if (s == SEQ_RET) begin
            case (n)
                3'h0: seq_addr = wp_reg + WS_R13;
                3'h1: seq_addr = wp_reg + WS_R14;
                default: seq_addr = wp_reg + WS_R15;
            endcase
        end
    endfunction : seq_addr

    // Command and interrupt decode
    wire idle = state_reg == S_IDLE;
    wire cmd_wr = reg_write && reg_addr == REG_CMD && idle && !reset_pend_reg;
    wire [2:0] cmd_op = reg_wdata[2:0];
    wire boundary = cmd_wr && cmd_op == CMD_DONE;
    wire int_ok = int_seen_reg && int_code_reg != 4'h0 && int_code_reg <= st_reg[3:0];
    wire take_rst = idle && reset_pend_reg;
    wire take_nmi = boundary && !inhibit_reg && nmi_pend_reg;
    wire take_int = boundary && !inhibit_reg && !nmi_pend_reg && int_ok;
    wire start_bit = cmd_wr && (cmd_op == CMD_SET || cmd_op == CMD_TEST);
    wire start_link = cmd_wr && cmd_op == CMD_LINK;
    wire start_xop = cmd_wr && cmd_op == CMD_XOP;
    wire start_ret = cmd_wr && cmd_op == CMD_RET;
    wire start_trap = take_rst || take_nmi || take_int || start_link || start_xop;
    wire start_any = start_trap || start_bit || start_ret;
    wire [15:0] xop_vec = VEC_XOP_BASE + {10'h000, reg_wdata[7:4], 2'b00};
    wire [15:0] int_vec = {10'h000, int_code_reg, 2'b00};
    wire [15:0] vec_pick = take_rst ? VEC_RESET : take_nmi ? VEC_NMI :
        take_int ? int_vec : start_link ? target_reg : xop_vec;

    // Memory step decode
    wire [15:0] acc_addr = seq_addr(seq_reg, step_reg);
    wire acc_write = seq_reg == SEQ_TRAP && step_reg >= 3'h2 && step_reg <= 3'h4;
    wire [15:0] acc_wdata = step_reg == 3'h2 ? wp_reg : step_reg == 3'h3 ? pc_reg : st_reg;
    wire mem_done = state_reg == S_MEM2 && mem_ready;
    wire last_step = seq_reg == SEQ_BIT || (seq_reg == SEQ_TRAP && step_reg == TRAP_LAST) ||
        (seq_reg == SEQ_RET && step_reg == RET_LAST);
    wire trap_done = mem_done && seq_reg == SEQ_TRAP && step_reg == TRAP_LAST;
    wire ret_done = mem_done && seq_reg == SEQ_RET && step_reg == RET_LAST;

    // Bit address: base bits 3..14 plus signed displacement
    wire [15:0] base_src = state_reg == S_MEM2 ? data_in : base_reg;
    wire [11:0] io_addr = base_src[12:1] + {{4{instr_reg[7]}}, instr_reg[7:0]};

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (start_any) begin
                    state_next = S_SETUP;
                end else if (hold_seen_reg) begin
                    state_next = S_HOLD;
                end
            end
            S_SETUP: state_next = hold_seen_reg ? S_HOLD : S_MEM1;
            S_MEM1: state_next = S_MEM2;
            S_MEM2: begin
                if (mem_ready) begin
                    state_next = !last_step ? S_SETUP : seq_reg == SEQ_BIT ? S_IO_ADDR : S_IDLE;
                end
            end
            S_HOLD: state_next = hold_seen_reg ? S_HOLD : resume_reg;
            S_IO_ADDR: state_next = hold_seen_reg ? S_HOLD : S_IO_XFER;
            S_IO_XFER: state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    // Sequencer and context registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            resume_reg <= S_IDLE;
            seq_reg <= SEQ_TRAP;
            kind_reg <= K_RESET;
            step_reg <= 3'h0;
            vec_reg <= 16'h0000;
            level_reg <= 4'h0;
            io_out_reg <= 1'b0;
            cyc_write_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next == S_HOLD && state_reg != S_HOLD) begin
                resume_reg <= state_reg;
            end
            if (state_reg == S_SETUP && state_next == S_MEM1) begin
                cyc_write_reg <= acc_write;
            end
            if (idle && start_any) begin
                seq_reg <= start_trap ? SEQ_TRAP : start_ret ? SEQ_RET : SEQ_BIT;
                kind_reg <= take_rst ? K_RESET : take_nmi ? K_NMI : take_int ? K_INT :
                    start_link ? K_LINK : K_XOP;
                step_reg <= 3'h0;
                vec_reg <= vec_pick;
                level_reg <= take_int ? int_code_reg : 4'h0;
                io_out_reg <= cmd_op == CMD_SET;
            end else if (mem_done && !last_step) begin
                step_reg <= step_reg + 3'h1;
            end
        end
    end

    // Architectural state and captured words
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wp_reg <= 16'h0000;
            pc_reg <= 16'h0000;
            st_reg <= ST_RESET;
            instr_reg <= 16'h0000;
            target_reg <= 16'h0000;
            nwp_reg <= 16'h0000;
            npc_reg <= 16'h0000;
            base_reg <= 16'h0000;
            fetched_reg <= 16'h0000;
            inhibit_reg <= 1'b0;
        end else begin
            if (idle && reg_write && reg_addr == REG_WP) wp_reg <= reg_wdata;
            if (idle && reg_write && reg_addr == REG_PC) pc_reg <= reg_wdata;
            if (idle && reg_write && reg_addr == REG_ST) st_reg <= reg_wdata;
            if (idle && reg_write && reg_addr == REG_INSTR) instr_reg <= reg_wdata;
            if (idle && reg_write && reg_addr == REG_TARGET) target_reg <= reg_wdata;
            if (boundary && inhibit_reg) inhibit_reg <= 1'b0;
            if (mem_done && step_reg == 3'h0 && seq_reg != SEQ_BIT) nwp_reg <= data_in;
            if (mem_done && step_reg == 3'h1) npc_reg <= data_in;
            if (mem_done && seq_reg == SEQ_BIT) base_reg <= data_in;
            if (trap_done) begin
                fetched_reg <= data_in;
                wp_reg <= nwp_reg;
                pc_reg <= npc_reg + WORD_STEP;
                inhibit_reg <= kind_reg == K_INT || kind_reg == K_RESET;
                if (kind_reg == K_RESET) begin
                    st_reg <= ST_RESET;
                end else if (kind_reg == K_INT) begin
                    st_reg[3:0] <= level_reg - 4'h1;
                end else if (kind_reg == K_XOP) begin
                    st_reg[ST_XOP_POS] <= 1'b1;
                end
            end
            if (ret_done) begin
                wp_reg <= nwp_reg;
                pc_reg <= npc_reg;
                st_reg <= data_in;
            end
            if (state_reg == S_IO_XFER && !io_out_reg) begin
                st_reg[ST_EQ_POS] <= serial_in_bit;
            end
        end
    end

    // Input capture and pending events; a new trap edge wins over its clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_seen_reg <= 1'b0;
            int_seen_reg <= 1'b0;
            int_code_reg <= 4'h0;
            nmi_prev_reg <= 1'b1;
            nmi_pend_reg <= 1'b0;
            reset_pend_reg <= 1'b1;
        end else begin
            hold_seen_reg <= !bus_yield_request_n;
            int_seen_reg <= !int_request_n;
            if (!int_request_n) int_code_reg <= int_level_code;
            nmi_prev_reg <= nmi_trap_request_n;
            nmi_pend_reg <= (nmi_prev_reg && !nmi_trap_request_n) || (nmi_pend_reg && !take_nmi);
            if (take_rst) reset_pend_reg <= 1'b0;
        end
    end

    // Pin values for the coming cycle
    wire mem_next = state_next == S_MEM1 || state_next == S_MEM2;
    wire load_cyc = state_reg == S_SETUP && state_next == S_MEM1;
    wire cur_write = load_cyc ? acc_write : cyc_write_reg;
    wire oe_next = state_next != S_HOLD;
    wire [14:0] addr_next = load_cyc ? word_of(acc_addr) :
        state_next == S_IO_ADDR ? {3'h0, io_addr} : addr_out;
    wire [15:0] rd_mux = reg_addr == REG_WP ? wp_reg : reg_addr == REG_PC ? pc_reg :
        reg_addr == REG_ST ? st_reg : reg_addr == REG_INSTR ? instr_reg :
        reg_addr == REG_TARGET ? target_reg : reg_addr == REG_FETCHED ? fetched_reg :
        reg_addr == REG_STATUS ? {9'h000, !idle, nmi_pend_reg, inhibit_reg, int_code_reg} : 16'h0000;

    // Output flip-flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            addr_out <= 15'h0000;
            addr_oe <= 1'b1;
            data_out <= 16'h0000;
            data_oe <= 1'b0;
            read_direction <= 1'b0;
            mem_cycle_n <= 1'b1;
            write_strobe_n <= 1'b1;
            bus_ctl_oe <= 1'b1;
            bus_yield_ack <= 1'b0;
            serial_out_bit <= 1'b0;
            io_strobe <= 1'b0;
        end else begin
            reg_rdata <= reg_read ? rd_mux : 16'h0000;
            addr_out <= addr_next;
            addr_oe <= oe_next;
            if (load_cyc) data_out <= acc_wdata;
            data_oe <= mem_next && cur_write;
            read_direction <= mem_next && !cur_write;
            mem_cycle_n <= !mem_next;
            write_strobe_n <= !(mem_next && cur_write);
            bus_ctl_oe <= oe_next;
            bus_yield_ack <= state_next == S_HOLD;
            if (state_next == S_IO_ADDR) serial_out_bit <= instr_reg[INSTR_VAL_POS];
            io_strobe <= state_next == S_IO_XFER && io_out_reg;
        end
    end

    // Helper counts of memory cycles inside a trap sequence
    logic [2:0] st_cnt_reg, fe_cnt_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_cnt_reg <= 3'h0;
            fe_cnt_reg <= 3'h0;
        end else if (idle) begin
            st_cnt_reg <= 3'h0;
            fe_cnt_reg <= 3'h0;
        end else if (mem_done && seq_reg == SEQ_TRAP) begin
            if (cyc_write_reg) st_cnt_reg <= st_cnt_reg + 3'h1;
            else fe_cnt_reg <= fe_cnt_reg + 3'h1;
        end
    end

    // Non-wait cycles that a hold request has waited for its acknowledge
    logic [3:0] yield_wait_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) yield_wait_reg <= 4'h0;
        else if (bus_yield_request_n || bus_yield_ack) yield_wait_reg <= 4'h0;
        else if (!(state_reg == S_MEM2 && !mem_ready)) yield_wait_reg <= yield_wait_reg + 4'h1;
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_hold_ack_bound: assert property (yield_wait_reg <= 4'(2 * MAX_MEM_RUN + 2))
        else $error("hold ack late");
    chk_hold_floats: assert property (bus_yield_ack |->
        !addr_oe && !data_oe && !bus_ctl_oe && mem_cycle_n && !io_strobe)
        else $error("bus driven in hold");
    chk_hold_resume: assert property ((bus_yield_ack && bus_yield_request_n)
        |-> ##[1:2] !bus_yield_ack)
        else $error("hold not released");
    chk_hold_at_gap: assert property ($rose(bus_yield_ack) |->
        $past(state_reg) != S_MEM1 && $past(mem_cycle_n))
        else $error("hold entered inside memory cycle");
    chk_redrive_cycle: assert property (($fell(bus_yield_ack) && state_reg == S_IO_ADDR)
        |-> !io_strobe && addr_oe ##1 (io_strobe == io_out_reg))
        else $error("no redrive cycle");
    chk_strobe_setup: assert property (io_strobe |-> mem_cycle_n && addr_oe &&
        $stable(addr_out) && $stable(serial_out_bit) && $past(addr_oe))
        else $error("strobe without setup");
    chk_strobe_single: assert property (io_strobe |=> !io_strobe)
        else $error("strobe too long");
    chk_test_quiet: assert property ((state_reg == S_IO_XFER && !io_out_reg) |->
        !io_strobe)
        else $error("strobe on input");
    chk_test_flag: assert property ((state_reg == S_IO_XFER && !io_out_reg) |=>
        st_reg[ST_EQ_POS] == $past(serial_in_bit))
        else $error("equal flag wrong");
    chk_switch_cycles: assert property (trap_done |->
        st_cnt_reg == 3'(MAX_MEM_RUN) && fe_cnt_reg == 3'(MAX_MEM_RUN - 1))
        else $error("context switch cycle count");
    chk_mask_update: assert property ((trap_done && kind_reg == K_INT) |=>
        st_reg[3:0] == $past(level_reg) - 4'h1 && inhibit_reg)
        else $error("mask not lowered");
    chk_int_accept: assert property ((kind_reg == K_INT && state_reg == S_SETUP && $past(idle)) |->
        level_reg != 4'h0 && level_reg <= $past(st_reg[3:0]) && !$past(inhibit_reg))
        else $error("interrupt taken against mask");

    cov_hold: cover property ($rose(bus_yield_ack));
    cov_bit_out: cover property (io_strobe);
    cov_int_entry: cover property (trap_done && kind_reg == K_INT);
    cov_io_hold: cover property ($fell(bus_yield_ack) && state_reg == S_IO_ADDR);
endmodule : cpc_ctl

// [cpc_far_side.sv]
`timescale 1ns/1ps
module cpc_far_side (
    // Clock
    input wire logic sys_clk,
    // Memory bus from the processor
    input wire logic [14:0] addr_out,
    input wire logic [15:0] data_out,
    input wire logic read_direction,
    input wire logic mem_cycle_n,
    input wire logic write_strobe_n,
    input wire logic [1:0] wait_n,
    output logic [15:0] data_in,
    output logic mem_ready,
    // Bit I/O lines
    input wire logic serial_out_bit,
    input wire logic io_strobe,
    output logic serial_in_bit
);
    logic [15:0] mem [0:32767];
    logic [15:0] last_rd = 16'h0000;
    logic [2:0] cyc = 3'h0;
    logic [4095:0] out_bits = '0;
    logic [4095:0] in_bits = '0;
    int strobes = 0;
    int reads = 0;
    int writes = 0;
    // Word-wide memory, one entry per even byte address
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
    end
    // Ready after the chosen number of wait cycles in the second cycle onward
    assign mem_ready = !mem_cycle_n && (cyc > {1'b0, wait_n});
    // Read data only during a read; otherwise the inverse of the last value
    assign data_in = (read_direction && !mem_cycle_n) ? mem[addr_out] : ~last_rd;
    // Input bit chosen by the bit address on A3 to A14
    assign serial_in_bit = in_bits[addr_out[11:0]];
    // Cycle counter, write capture and access counts
    always @(posedge sys_clk) begin
        last_rd <= data_in;
        cyc <= mem_cycle_n ? 3'h0 : cyc + 3'h1;
        if (mem_ready && !write_strobe_n) begin
            mem[addr_out] <= data_out;
            writes <= writes + 1;
        end
        if (mem_ready && read_direction) reads <= reads + 1;
    end
    // Output bit taken when the strobe rises
    always @(posedge io_strobe) begin
        out_bits[addr_out[11:0]] <= serial_out_bit;
        strobes <= strobes + 1;
    end
endmodule : cpc_far_side

// [test_cpc_ctl.sv]
`timescale 1ns/1ps
module test_cpc_ctl;
    import cpc_pkg::*;
    logic sys_clk, rst, reg_write, reg_read, addr_oe, data_oe, read_direction, mem_cycle_n;
    logic write_strobe_n, bus_ctl_oe, mem_ready, bus_yield_request_n, bus_yield_ack;
    logic serial_out_bit, serial_in_bit, io_strobe, int_request_n, nmi_trap_request_n;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, data_in, data_out, s;
    logic [14:0] addr_out;
    logic [3:0] int_level_code;
    logic [1:0] wait_n;
    int errors = 0;
    int num_checks = 0;
    int n;
    // Design and its far side
    cpc_ctl uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .addr_out(addr_out),
        .addr_oe(addr_oe), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .read_direction(read_direction), .mem_cycle_n(mem_cycle_n), .write_strobe_n(write_strobe_n),
        .bus_ctl_oe(bus_ctl_oe), .mem_ready(mem_ready), .bus_yield_request_n(bus_yield_request_n),
        .bus_yield_ack(bus_yield_ack), .serial_out_bit(serial_out_bit), .serial_in_bit(serial_in_bit),
        .io_strobe(io_strobe), .int_request_n(int_request_n), .int_level_code(int_level_code),
        .nmi_trap_request_n(nmi_trap_request_n));
    cpc_far_side far (.sys_clk(sys_clk), .addr_out(addr_out), .data_out(data_out),
        .read_direction(read_direction), .mem_cycle_n(mem_cycle_n), .write_strobe_n(write_strobe_n),
        .wait_n(wait_n), .data_in(data_in), .mem_ready(mem_ready), .serial_out_bit(serial_out_bit),
        .io_strobe(io_strobe), .serial_in_bit(serial_in_bit));
    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // One-cycle write and read strobes on the register port
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : rd
    task automatic chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        cmp(d, exp);
    endtask : chk
    task automatic wait_idle;
        logic [15:0] d;
        d = 16'hffff;
        for (int i = 0; i < 100 && d[6] !== 1'b0; i++) rd(REG_STATUS, d);
        cmp({15'h0, d[6]}, 16'h0);
    endtask : wait_idle
    task automatic cmd(input logic [15:0] c);
        wr(REG_CMD, c);
        wait_idle();
    endtask : cmd
    // Context switch with known old context and vector
    task automatic trap(input logic [15:0] c, v, owp, opc, ost, nwp, npc);
        far.mem[v[15:1]] = nwp;
        far.mem[v[15:1] + 15'h1] = npc;
        wr(REG_WP, owp);
        wr(REG_PC, opc);
        wr(REG_ST, ost);
        cmd(c);
        chk(REG_WP, nwp);
        chk(REG_PC, npc + WORD_STEP);
        cmp(far.mem[(nwp + WS_R13) >> 1], owp);
        cmp(far.mem[(nwp + WS_R14) >> 1], opc);
        cmp(far.mem[(nwp + WS_R15) >> 1], ost);
    endtask : trap
    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
    initial begin
        {reg_write, reg_read, reg_addr, reg_wdata, wait_n, int_level_code} = '0;
        {rst, bus_yield_request_n, int_request_n, nmi_trap_request_n} = 4'hf;
        repeat (10) @(posedge sys_clk);
        far.mem[0] = 16'h0100;
        far.mem[1] = 16'h0200;
        far.mem[16'h0100] = 16'h1234;
        rst <= 1'b0;
        wait_idle();
        chk(REG_WP, 16'h0100);
        chk(REG_PC, 16'h0202);
        chk(REG_ST, ST_RESET);
        chk(REG_FETCHED, 16'h1234);
        cmp(16'(far.reads), 16'h3);
        cmp(16'(far.writes), 16'h3);
        $display("reset trap done");
        cmd(16'h0);
        wr(REG_WP, 16'h0300);
        int_level_code <= 4'h6;
        int_request_n <= 1'b0;
        cmd(16'h0);
        chk(REG_WP, 16'h0300);
        int_level_code <= 4'h0;
        cmd(16'h0);
        chk(REG_WP, 16'h0300);
        int_level_code <= 4'h3;
        trap(16'h0, 16'h000c, 16'h0300, 16'h0310, 16'h0005, 16'h0400, 16'h0500);
        rd(REG_ST, s);
        cmp({12'h0, s[3:0]}, 16'h2);
        int_level_code <= 4'h1;
        cmd(16'h0);
        chk(REG_WP, 16'h0400);
        trap(16'h0, 16'h0004, 16'h0400, 16'h0502, 16'h0002, 16'h0600, 16'h0700);
        int_request_n <= 1'b1;
        cmd({13'h0, CMD_RET});
        chk(REG_WP, 16'h0400);
        chk(REG_ST, 16'h0002);
        $display("interrupt nesting done");
        wr(REG_TARGET, 16'h0800);
        trap({13'h0, CMD_LINK}, 16'h0800, 16'h0900, 16'h0910, 16'h0000, 16'h0a00, 16'h0b00);
        trap({8'h0, 4'h2, 1'b0, CMD_XOP}, 16'h0048, 16'h0a00, 16'h0b02, 16'h0000, 16'h0c00, 16'h0d00);
        rd(REG_ST, s);
        cmp({15'h0, s[ST_XOP_POS]}, 16'h1);
        cmd(16'h0);
        nmi_trap_request_n <= 1'b0;
        @(posedge sys_clk);
        nmi_trap_request_n <= 1'b1;
        trap(16'h0, VEC_NMI, 16'h0c00, 16'h0d02, 16'h0000, 16'h0e00, 16'h0f00);
        $display("context switches done");
        wr(REG_WP, 16'h1000);
        far.out_bits[12'h0ff] = 1'b1;
        for (int i = 0; i < 3; i++) begin
            n = far.strobes;
            far.mem[(16'h1000 + WS_R12) >> 1] = (i == 2) ? 16'h1ffe : 16'h0100;
            wr(REG_INSTR, (i == 0) ? 16'h01ff : (i == 1) ? 16'h007f : 16'h0180);
            cmd({13'h0, CMD_SET});
            cmp(far.out_bits[(i == 0) ? 12'h07f : (i == 1) ? 12'h0ff : 12'hf7f], (i == 1) ? 16'h0 : 16'h1);
            cmp(16'(far.strobes), 16'(n + 1));
        end
        far.mem[(16'h1000 + WS_R12) >> 1] = 16'h0100;
        wr(REG_INSTR, 16'h0005);
        for (int v = 1; v >= 0; v--) begin
            far.in_bits[12'h085] = v[0];
            cmd({13'h0, CMD_TEST});
            rd(REG_ST, s);
            cmp({15'h0, s[ST_EQ_POS]}, 16'(v));
            cmp(16'(far.strobes), 16'(n + 1));
        end
        $display("bit io done");
        @(posedge sys_clk);
        bus_yield_request_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) cmp({bus_yield_ack, addr_oe, bus_ctl_oe, data_oe}, 16'h8);
        @(posedge sys_clk);
        bus_yield_request_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) cmp({bus_yield_ack, addr_oe, bus_ctl_oe}, 16'h3);
        wr(REG_INSTR, 16'h0103);
        wait_n <= 2'h1;
        wr(REG_CMD, {13'h0, CMD_SET});
        n = far.strobes;
        bus_yield_request_n <= 1'b0;
        for (int i = 0; i < 20 && bus_yield_ack !== 1'b1; i++) @(negedge sys_clk) s = 16'(i + 1);
        cmp({15'h0, s <= 16'd12}, 16'h1);
        repeat (4) @(posedge sys_clk);
        cmp(16'(far.strobes), 16'(n));
        bus_yield_request_n <= 1'b1;
        wait_idle();
        cmp(16'(far.strobes), 16'(n + 1));
        cmp({15'h0, far.out_bits[12'h083]}, 16'h1);
        chk(REG_WP, 16'h1000);
        $display("bus hold done");
        close_out();
    end
endmodule : test_cpc_ctl
